/* core/npic_pkg.sv */
package npic_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NPIC_NVEC = 14;
	localparam int NPIC_NLVL = 4;

	// ----------------------------------------
	// APB register offsets
	// ----------------------------------------
	localparam logic [7:0] NPIC_OFS_CC     = 8'h00;
	localparam logic [7:0] NPIC_OFS_PRIO0  = 8'h04;
	localparam logic [7:0] NPIC_OFS_PRIO3  = 8'h10;
	localparam logic [7:0] NPIC_OFS_ENABLE = 8'h14;
	localparam logic [7:0] NPIC_OFS_PEND   = 8'h18;
	localparam logic [7:0] NPIC_OFS_EDGE   = 8'h1c;
	localparam logic [7:0] NPIC_OFS_HALTOK = 8'h20;
	localparam logic [7:0] NPIC_OFS_STAT   = 8'h24;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int         NPIC_CC_PH      = 5;
	localparam int         NPIC_CC_PL      = 3;
	localparam logic [7:0] NPIC_CC_RST     = 8'hea;
	localparam logic [7:0] NPIC_PRIO_RST   = 8'hff;
	localparam logic [1:0] NPIC_LVL0       = 2'h2;
	localparam logic [1:0] NPIC_LVL1       = 2'h1;
	localparam logic [1:0] NPIC_LVL2       = 2'h0;
	localparam logic [1:0] NPIC_LVL3       = 2'h3;
	localparam logic [13:0] NPIC_HALTOK_RST = 14'h20be;
	localparam logic [13:0] NPIC_EDGE_RST  = 14'h003c;

	// ----------------------------------------
	// Vector addresses
	// ----------------------------------------
	localparam logic [15:0] NPIC_VEC_RESET = 16'hfffe;
	localparam logic [15:0] NPIC_VEC_TRAP  = 16'hfffc;
	localparam logic [15:0] NPIC_VEC_BASE  = 16'hfffa;

	// ----------------------------------------
	// CPU instruction events
	// ----------------------------------------
	typedef struct packed {
		logic       instr_done;
		logic       trap;
		logic       unmask;
		logic       mask;
		logic       wait_for_interrupt_instr;
		logic       halt;
		logic       return_from_interrupt;
		logic       cc_load;
		logic [7:0] cc_data;
		logic       stack_done;
	} npic_cpu_t;

	typedef enum logic [3:0] {
		NPIC_RUN   = 4'b0001,
		NPIC_STACK = 4'b0010,
		NPIC_VECT  = 4'b0100,
		NPIC_SLEEP = 4'b1000
	} npic_state_t;

endpackage

/* core/npic_ctrl.sv */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module npic_ctrl
	import npic_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Interrupt sources
	input  wire logic [27:0] ext_pin_i,
	input  wire logic [27:0] ext_sel_i,
	input  wire logic [13:0] per_flag_i,
	input  wire logic [13:0] per_en_i,
	input  wire logic [13:0] per_clr_i,
	// CPU sequencer
	input  wire npic_cpu_t   cpu_i,
	output logic             stack_req_o,
	output logic             fetch_o,
	output logic      [15:0] vec_addr_o,
	output logic      [7:0]  cc_o,
	output logic             sleep_o
);

	// ----------------------------------------
	// Input synchronisers for pins
	// ----------------------------------------
	// Third stage keeps the previous sample so rising edges can be seen
	logic [27:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
	logic [27:0] nxt_pin_s1, nxt_pin_s2, nxt_pin_s3;

	always_comb begin
		nxt_pin_s1 = ext_pin_i;
		nxt_pin_s2 = pin_s1_ff;
		nxt_pin_s3 = pin_s2_ff;
	end

	always_ff @(posedge clk_sys_i) begin
		pin_s1_ff <= nxt_pin_s1;
		pin_s2_ff <= nxt_pin_s2;
		pin_s3_ff <= nxt_pin_s3;
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	npic_state_t  st_ff, nxt_st;
	logic [7:0]   cc_ff, nxt_cc;
	logic [27:0]  prio_ff, nxt_prio;
	logic [13:0]  en_ff, nxt_en;
	logic [13:0]  edge_ff, nxt_edge;
	logic [13:0]  haltok_ff, nxt_haltok;
	logic [13:0]  pend_ff, nxt_pend;
	logic         trap_ff, nxt_trap;
	logic         halted_ff, nxt_halted;
	logic         first_ff, nxt_first;
	logic         boot_ff, nxt_boot;
	logic [4:0]   sel_ff, nxt_sel;
	logic         sel_nmi_ff, nxt_sel_nmi;
	logic [31:0]  prdata_ff, nxt_prdata;
	logic         pready_ff, nxt_pready;
	logic         pslverr_ff, nxt_pslverr;

	// ----------------------------------------
	// Request combining and arbitration
	// ----------------------------------------
	logic [13:0] raw_req;
	logic [13:0] eligible;
	logic [1:0]  cur_lvl;
	logic        found;
	logic [4:0]  best_idx;
	logic [1:0]  best_rank;
	logic [1:0]  cand_rank;
	logic        any_pend;
	logic        halt_wake;

	// Levels ranked 0..3 so one compare orders them
	function automatic logic [1:0] rank(input logic [1:0] code);
		unique case (code)
			NPIC_LVL0: rank = 2'h0;
			NPIC_LVL1: rank = 2'h1;
			NPIC_LVL2: rank = 2'h2;
			default:   rank = 2'h3;
		endcase
	endfunction

	always_comb begin
		// Edge part sees a rise between the last two synchronised samples
		for (int i = 0; i < NPIC_NVEC; i++) begin
			raw_req[i] = (per_flag_i[i] & per_en_i[i])
				| (|(pin_s3_ff[2*i +: 2] & ext_sel_i[2*i +: 2]))
				| (|(pin_s2_ff[2*i +: 2] & ext_sel_i[2*i +: 2] & ~pin_s3_ff[2*i +: 2]));
		end
		cur_lvl   = {cc_ff[NPIC_CC_PH], cc_ff[NPIC_CC_PL]};
		// Compare is strict, so the lowest index keeps a tie
		found     = 1'b0;
		best_idx  = 5'h0;
		best_rank = 2'h0;
		for (int i = 0; i < NPIC_NVEC; i++) begin
			cand_rank   = rank(prio_ff[2*i +: 2]);
			eligible[i] = pend_ff[i] & en_ff[i] & (cand_rank > rank(cur_lvl))
				& (~first_ff | haltok_ff[i]);
			if (eligible[i] && (!found || cand_rank > best_rank)) begin
				found     = 1'b1;
				best_idx  = 5'(i);
				best_rank = cand_rank;
			end
		end
		any_pend  = |(pend_ff & en_ff);
		halt_wake = |(pend_ff & en_ff & haltok_ff);
	end

	// ----------------------------------------
	// Sequencer and level bits
	// ----------------------------------------
	logic        wr_acc;
	logic [1:0]  fld;
	int          fpos;

	always_comb begin
		nxt_st      = st_ff;
		nxt_cc      = cc_ff;
		// Trap is latched so an instruction still in flight cannot lose it
		nxt_trap    = trap_ff | cpu_i.trap;
		nxt_halted  = halted_ff;
		nxt_first   = first_ff;
		nxt_boot    = 1'b0;
		nxt_sel     = sel_ff;
		nxt_sel_nmi = sel_nmi_ff;
		// Software writes of the level bits
		if (cpu_i.unmask || cpu_i.wait_for_interrupt_instr || cpu_i.halt) begin
			nxt_cc[NPIC_CC_PH] = NPIC_LVL0[1];
			nxt_cc[NPIC_CC_PL] = NPIC_LVL0[0];
		end
		if (cpu_i.mask) begin
			nxt_cc[NPIC_CC_PH] = NPIC_LVL3[1];
			nxt_cc[NPIC_CC_PL] = NPIC_LVL3[0];
		end
		if (cpu_i.return_from_interrupt || cpu_i.cc_load) begin
			nxt_cc = cpu_i.cc_data;
		end
		unique case (st_ff)
			NPIC_RUN: begin
				if (boot_ff) begin
					nxt_sel_nmi = 1'b1;
					nxt_sel     = 5'h1f;
					nxt_st      = NPIC_VECT;
				end else if (cpu_i.instr_done && (trap_ff || cpu_i.trap)) begin
					nxt_sel_nmi = 1'b1;
					nxt_sel     = 5'h1e;
					nxt_trap    = 1'b0;
					nxt_st      = NPIC_STACK;
				end else if (cpu_i.instr_done && found) begin
					nxt_sel_nmi = 1'b0;
					nxt_sel     = best_idx;
					nxt_first   = 1'b0;
					nxt_st      = NPIC_STACK;
				end else if (cpu_i.wait_for_interrupt_instr || cpu_i.halt) begin
					nxt_halted = cpu_i.halt;
					nxt_st     = NPIC_SLEEP;
				end
			end
			NPIC_STACK: begin
				if (cpu_i.stack_done) begin
					if (sel_nmi_ff) begin
						nxt_cc[NPIC_CC_PH] = NPIC_LVL3[1];
						nxt_cc[NPIC_CC_PL] = NPIC_LVL3[0];
					end else begin
						nxt_cc[NPIC_CC_PH] = prio_ff[2*sel_ff + 1];
						nxt_cc[NPIC_CC_PL] = prio_ff[2*sel_ff];
					end
					nxt_st = NPIC_VECT;
				end
			end
			NPIC_VECT: begin
				if (sel_ff == 5'h1f) begin
					nxt_cc[NPIC_CC_PH] = NPIC_LVL3[1];
					nxt_cc[NPIC_CC_PL] = NPIC_LVL3[0];
				end
				nxt_st = NPIC_RUN;
			end
			NPIC_SLEEP: begin
				if (trap_ff || cpu_i.trap) begin
					nxt_st = NPIC_RUN;
				end else if (halted_ff ? halt_wake : any_pend) begin
					// Halt wake arms the halt-capable filter for one entry
					nxt_first = halted_ff;
					nxt_st    = NPIC_RUN;
				end
			end
		endcase
	end

	// ----------------------------------------
	// Pending latches
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < NPIC_NVEC; i++) begin
			// Level sources follow the request; edge sources hold it
			nxt_pend[i] = edge_ff[i] ? pend_ff[i] : raw_req[i];
			if (st_ff == NPIC_STACK && cpu_i.stack_done && !sel_nmi_ff && sel_ff == 5'(i)
				&& edge_ff[i]) begin
				nxt_pend[i] = 1'b0;
			end
			if (per_clr_i[i]) begin
				nxt_pend[i] = 1'b0;
			end
			// A new event in the clearing cycle is kept
			if (raw_req[i] && edge_ff[i]) begin
				nxt_pend[i] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	always_comb begin
		wr_acc      = psel_i & penable_i & pwrite_i;
		nxt_prio    = prio_ff;
		nxt_en      = en_ff;
		nxt_edge    = edge_ff;
		nxt_haltok  = haltok_ff;
		nxt_prdata  = 32'h0;
		nxt_pready  = psel_i & ~penable_i;
		nxt_pslverr = 1'b0;
		fld         = 2'h0;
		fpos        = 0;
		if (wr_acc && paddr_i >= NPIC_OFS_PRIO0 && paddr_i <= NPIC_OFS_PRIO3
			&& paddr_i[1:0] == 2'h0) begin
			for (int f = 0; f < 4; f++) begin
				fld  = pwdata_i[2*f +: 2];
				fpos = 8 * (int'(paddr_i[4:2]) - 1) + 2 * f;
				// Top nibble of the last bank has no vectors behind it
				if (fld != NPIC_LVL0 && fpos < 28) begin
					nxt_prio[fpos +: 2] = fld;
				end
			end
		end
		if (wr_acc && paddr_i == NPIC_OFS_ENABLE) nxt_en     = pwdata_i[13:0];
		if (wr_acc && paddr_i == NPIC_OFS_EDGE)   nxt_edge   = pwdata_i[13:0];
		if (wr_acc && paddr_i == NPIC_OFS_HALTOK) nxt_haltok = pwdata_i[13:0];
		// Read data is latched in setup so it stands for the whole access cycle
		if (psel_i && !penable_i) begin
			unique case (paddr_i)
				NPIC_OFS_CC:     nxt_prdata = {24'h0, cc_ff};
				NPIC_OFS_PRIO0:  nxt_prdata = {24'h0, prio_ff[7:0]};
				8'h08:           nxt_prdata = {24'h0, prio_ff[15:8]};
				8'h0c:           nxt_prdata = {24'h0, prio_ff[23:16]};
				NPIC_OFS_PRIO3:  nxt_prdata = {24'h0, 4'hf, prio_ff[27:24]};
				NPIC_OFS_ENABLE: nxt_prdata = {18'h0, en_ff};
				NPIC_OFS_PEND:   nxt_prdata = {18'h0, pend_ff};
				NPIC_OFS_EDGE:   nxt_prdata = {18'h0, edge_ff};
				NPIC_OFS_HALTOK: nxt_prdata = {18'h0, haltok_ff};
				// Status view lets software spot a stuck sequencer
				NPIC_OFS_STAT:   nxt_prdata = {27'h0, halted_ff, st_ff};
				default:         nxt_pslverr = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st_ff      <= NPIC_RUN;
			cc_ff      <= NPIC_CC_RST;
			prio_ff    <= {NPIC_PRIO_RST[3:0], {3{NPIC_PRIO_RST}}};
			// Sources start disabled so the boot fetch comes first
			en_ff      <= 14'h0;
			edge_ff    <= NPIC_EDGE_RST;
			haltok_ff  <= NPIC_HALTOK_RST;
			pend_ff    <= 14'h0;
			trap_ff    <= 1'b0;
			halted_ff  <= 1'b0;
			first_ff   <= 1'b0;
			boot_ff    <= 1'b1;
			sel_ff     <= 5'h1f;
			sel_nmi_ff <= 1'b1;
			prdata_ff  <= 32'h0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			cc_ff      <= nxt_cc;
			prio_ff    <= nxt_prio;
			en_ff      <= nxt_en;
			edge_ff    <= nxt_edge;
			haltok_ff  <= nxt_haltok;
			pend_ff    <= nxt_pend;
			trap_ff    <= nxt_trap;
			halted_ff  <= nxt_halted;
			first_ff   <= nxt_first;
			boot_ff    <= nxt_boot;
			sel_ff     <= nxt_sel;
			sel_nmi_ff <= nxt_sel_nmi;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic [15:0] vec_ff, nxt_vec;
	logic        stk_ff, fet_ff, slp_ff;

	always_comb begin
		// Maskable vectors step down by two bytes from the base
		nxt_vec = (sel_ff == 5'h1f) ? NPIC_VEC_RESET :
			(sel_ff == 5'h1e) ? NPIC_VEC_TRAP :
			16'(NPIC_VEC_BASE - {10'h0, sel_ff, 1'b0});
	end

	// Strobes follow the next state so they line up with the state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			vec_ff <= NPIC_VEC_RESET;
			stk_ff <= 1'b0;
			fet_ff <= 1'b0;
			slp_ff <= 1'b0;
		end else begin
			vec_ff <= nxt_vec;
			stk_ff <= (nxt_st == NPIC_STACK);
			fet_ff <= (nxt_st == NPIC_VECT);
			slp_ff <= (nxt_st == NPIC_SLEEP);
		end
	end

	assign prdata_o    = prdata_ff;
	assign pready_o    = pready_ff;
	assign pslverr_o   = pslverr_ff;
	assign stack_req_o = stk_ff;
	assign fetch_o     = fet_ff;
	assign vec_addr_o  = vec_ff;
	assign cc_o        = cc_ff;
	assign sleep_o     = slp_ff;

endmodule

/* verif/npic_cpu_model.sv */
`timescale 1ns/10ps
module npic_cpu_model
	import npic_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      srst_i,
	// Controller side
	input  wire logic      slow_i,
	input  wire logic      stack_req_i,
	input  wire logic      fetch_i,
	input  wire logic      sleep_i,
	input  wire npic_cpu_t op_i,
	output npic_cpu_t      cpu_o
);
	// ----
	// Sequencer
	// ----
	logic [2:0] cnt_ff;
	always_ff @(posedge clk_i) begin
		cnt_ff <= (srst_i || !stack_req_i || cpu_o.stack_done) ? 3'h0 : cnt_ff + 3'h1;
	end
	// Slow mode stretches stacking so entry timing is not assumed
	always_comb begin
		cpu_o = op_i;
		cpu_o.instr_done = !stack_req_i && !fetch_i && !sleep_i;
		cpu_o.stack_done = stack_req_i && cnt_ff == (slow_i ? 3'h5 : 3'h1);
	end
endmodule

/* verif/npic_ctrl_chk.sv */
`timescale 1ns/10ps
module npic_ctrl_chk
	import npic_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys_i,
	input wire logic        srst_i,
	// Core side
	input wire npic_cpu_t   cpu_i,
	input wire logic        stack_req_o,
	input wire logic        fetch_o,
	input wire logic [15:0] vec_addr_o,
	input wire logic [7:0]  cc_o,
	input wire logic        sleep_o
);
	// ----
	// Properties
	// ----
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	wire [1:0] lvl = {cc_o[5], cc_o[3]};
	property p_rst; disable iff (1'h0) srst_i |=> cc_o == NPIC_CC_RST; endproperty
	a_rst: assert property (p_rst) else $error("cc reset value");
	property p_boot; $fell(srst_i) |-> ##[1:3] (fetch_o && vec_addr_o == NPIC_VEC_RESET); endproperty
	a_boot: assert property (p_boot) else $error("no boot fetch");
	property p_entry; $rose(stack_req_o) |-> $past(cpu_i.instr_done || cpu_i.trap || sleep_o); endproperty
	a_entry: assert property (p_entry) else $error("entry mid instruction");
	property p_hold; stack_req_o && !cpu_i.stack_done |=> stack_req_o; endproperty
	a_hold: assert property (p_hold) else $error("stacking dropped");
	property p_vect; stack_req_o && cpu_i.stack_done |=> !stack_req_o && fetch_o; endproperty
	a_vect: assert property (p_vect) else $error("no fetch after stacking");
	property p_once; fetch_o |=> !fetch_o; endproperty
	a_once: assert property (p_once) else $error("fetch too long");
	property p_trap; fetch_o && vec_addr_o == NPIC_VEC_TRAP |-> lvl == NPIC_LVL3; endproperty
	a_trap: assert property (p_trap) else $error("trap level");
	property p_mask; cpu_i.mask && !stack_req_o |=> lvl == NPIC_LVL3; endproperty
	a_mask: assert property (p_mask) else $error("mask level");
	property p_open; (cpu_i.unmask || cpu_i.wait_for_interrupt_instr || cpu_i.halt) && !stack_req_o |=> lvl == NPIC_LVL0; endproperty
	a_open: assert property (p_open) else $error("unmask level");
	property p_return_from_interrupt; cpu_i.return_from_interrupt && !stack_req_o |=> lvl == $past({cpu_i.cc_data[5], cpu_i.cc_data[3]}); endproperty
	a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return level");
	property p_sleep; (cpu_i.wait_for_interrupt_instr || cpu_i.halt) && !stack_req_o |=> sleep_o; endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep");
endmodule
bind npic_ctrl npic_ctrl_chk chk_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cpu_i(cpu_i),
	.stack_req_o(stack_req_o), .fetch_o(fetch_o), .vec_addr_o(vec_addr_o), .cc_o(cc_o), .sleep_o(sleep_o));

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import npic_pkg::*;
	logic        srst_i = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
	logic        clk_sys_i, g, pready_o, pslverr_o, stack_req_o, fetch_o, sleep_o;
	logic [7:0]  paddr = 8'h0, cc_o;
	logic [15:0] vec_addr_o;
	logic [31:0] pwdata = 32'h0, seed = 32'h00013553, prdata_o, rd;
	logic [27:0] ext_pin = 28'h0;
	logic [13:0] per_flag = 14'h0, per_en = 14'h3fff, per_clr = 14'h0;
	logic [1:0]  lv [16];
	npic_cpu_t   op = '0, cpu;
	int          mismatches, comparisons, va, vb, vc, w, l;
	npic_ctrl dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .ext_pin_i(ext_pin), .ext_sel_i(28'h30), .per_flag_i(per_flag),
		.per_en_i(per_en), .per_clr_i(per_clr), .cpu_i(cpu), .stack_req_o(stack_req_o), .fetch_o(fetch_o),
		.vec_addr_o(vec_addr_o), .cc_o(cc_o), .sleep_o(sleep_o));
	npic_cpu_model cpu_u (.clk_i(clk_sys_i), .srst_i(srst_i), .slow_i(slow), .stack_req_i(stack_req_o),
		.fetch_i(fetch_o), .sleep_i(sleep_o), .op_i(op), .cpu_o(cpu));
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int rank(input logic [1:0] c);
		return (c == NPIC_LVL0) ? 0 : (c == NPIC_LVL1) ? 1 : (c == NPIC_LVL2) ? 2 : 3;
	endfunction
	function automatic logic [15:0] vaddr(input int v);
		return NPIC_VEC_BASE - 16'(2 * v);
	endfunction
	function automatic logic [7:0] lvlcc(input logic [1:0] c);
		return {2'h3, c[1], 1'h0, c[0], 3'h0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'h1;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (pready_o !== 1'h1 && n < 16);
		if (n >= 16) mismatches++;
		rd = prdata_o;
		g = pslverr_o;
		@(posedge clk_sys_i);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdp();
		apb(1'h0, NPIC_OFS_PEND, 32'h0);
	endtask
	// Kinds: 0 trap, 1 unmask, 2 mask, 3 wait, 4 halt, else return
	task automatic pulse(input int k, input logic [7:0] d);
		npic_cpu_t t;
		t = '0;
		t.cc_data = d;
		case (k)
			0: t.trap = 1'h1;
			1: t.unmask = 1'h1;
			2: t.mask = 1'h1;
			3: t.wait_for_interrupt_instr = 1'h1;
			4: t.halt = 1'h1;
			default: t.return_from_interrupt = 1'h1;
		endcase
		@(posedge clk_sys_i);
		op <= t;
		@(posedge clk_sys_i);
		op <= '0;
	endtask
	task automatic wfetch(input logic e);
		g = 1'h0;
		for (int n = 0; n < 40 && !g; n++) begin
			@(negedge clk_sys_i);
			g = fetch_o === 1'h1;
		end
		chk(g, e);
	endtask
	task automatic setprio();
		logic [7:0] d;
		for (int b = 0; b < 4; b++) begin
			d = {lv[4*b+3], lv[4*b+2], lv[4*b+1], lv[4*b]};
			apb(1'h1, NPIC_OFS_PRIO0 + 8'(4 * b), {24'h0, d});
			apb(1'h0, NPIC_OFS_PRIO0 + 8'(4 * b), 32'h0);
			chk(rd, {24'h0, (b == 3) ? 4'hf : d[7:4], d[3:0]});
		end
	endtask
	task automatic pin(input logic [27:0] p);
		ext_pin <= p;
		repeat (2) @(posedge clk_sys_i);
		ext_pin <= 28'h0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	// ----
	// Run
	// ----
	initial begin
		clk_sys_i = 1'h0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		srst_i <= 1'h0;
		apb(1'h0, NPIC_OFS_CC, 32'h0);
		chk(rd, {24'h0, NPIC_CC_RST});
		apb(1'h0, 8'h40, 32'h0);
		chk(g, 1'h1);
		apb(1'h1, NPIC_OFS_PRIO0, 32'hcf);
		apb(1'h1, NPIC_OFS_PRIO0, 32'h64);
		apb(1'h0, NPIC_OFS_PRIO0, 32'h0);
		chk(rd, 32'h44);
		apb(1'h1, NPIC_OFS_ENABLE, 32'h3fff);
		apb(1'h1, NPIC_OFS_EDGE, 32'h0);
		pulse(0, 8'h0);
		wfetch(1'h1);
		chk(vec_addr_o, NPIC_VEC_TRAP);
		pulse(5, NPIC_CC_RST);
		for (int it = 0; it < 12; it++) begin
			rd = rnd();
			slow <= rd[0];
			for (int i = 0; i < 16; i++) begin
				rd = rnd();
				lv[i] = (rd[1:0] == NPIC_LVL0) ? NPIC_LVL3 : rd[1:0];
			end
			setprio();
			rd = rnd();
			va = rd[7:0] % 14;
			vb = (va + 1 + rd[15:8] % 13) % 14;
			vc = rd[23:16] % 14;
			while (vc == va || vc == vb) vc = (vc + 1) % 14;
			w = (rank(lv[vb]) > rank(lv[va]) || (rank(lv[vb]) == rank(lv[va]) && vb < va)) ? vb : va;
			l = va + vb - w;
			pulse(1, 8'h0);
			per_flag <= (14'h1 << va) | (14'h1 << vb);
			wfetch(1'h1);
			chk(vec_addr_o, vaddr(w));
			chk({cc_o[5], cc_o[3]}, lv[w]);
			per_flag <= (14'h1 << l) | (14'h1 << vc);
			wfetch(rank(lv[vc]) > rank(lv[w]));
			if (g) begin
				chk(vec_addr_o, vaddr(vc));
				per_flag <= 14'h1 << l;
				pulse(5, lvlcc(lv[w]));
			end
			rdp();
			chk(rd[l], 1'h1);
			per_flag <= 14'h1 << l;
			pulse(5, 8'he0);
			wfetch(1'h1);
			chk(vec_addr_o, vaddr(l));
			per_flag <= 14'h0;
			pulse(5, 8'he0);
		end
		pulse(2, 8'h0);
		per_en <= 14'h3dff;
		per_flag <= 14'h200;
		rdp();
		chk(rd[9], 1'h0);
		per_en <= 14'h3fff;
		rdp();
		chk(rd[9], 1'h1);
		per_flag <= 14'h0;
		apb(1'h1, NPIC_OFS_EDGE, 32'h4);
		pin(28'h10);
		rdp();
		chk(rd[2], 1'h1);
		per_clr <= 14'h4;
		@(posedge clk_sys_i);
		per_clr <= 14'h0;
		rdp();
		chk(rd[2], 1'h0);
		pin(28'h20);
		rdp();
		chk(rd[2], 1'h1);
		pulse(1, 8'h0);
		wfetch(1'h1);
		chk(vec_addr_o, vaddr(2));
		rdp();
		chk(rd[2], 1'h0);
		pulse(5, 8'he0);
		for (int i = 0; i < 16; i++) lv[i] = NPIC_LVL1;
		setprio();
		pulse(4, 8'h0);
		per_flag <= 14'h100;
		repeat (10) @(posedge clk_sys_i);
		chk(sleep_o, 1'h1);
		per_flag <= 14'h2100;
		wfetch(1'h1);
		chk(vec_addr_o, vaddr(13));
		per_flag <= 14'h100;
		pulse(5, 8'he0);
		wfetch(1'h1);
		chk(vec_addr_o, vaddr(8));
		per_flag <= 14'h0;
		pulse(5, 8'he0);
		pulse(3, 8'h0);
		repeat (4) @(posedge clk_sys_i);
		chk(sleep_o, 1'h1);
		per_flag <= 14'h400;
		wfetch(1'h1);
		chk(vec_addr_o, vaddr(10));
		per_flag <= 14'h0;
		pulse(5, 8'he0);
		pulse(4, 8'h0);
		repeat (4) @(posedge clk_sys_i);
		pulse(0, 8'h0);
		wfetch(1'h1);
		chk(vec_addr_o, NPIC_VEC_TRAP);
		pulse(5, 8'he0);
		end_sim();
	end
endmodule
